// ---- include/pin_state_pkg.sv ----
/*
  Package for the pin state control block: CPU state encoding, pin bundle
  structs and reset values.
  Assumes a single 50 MHz clock domain and pins inside the device.
*/
package pin_state_pkg;

    localparam int unsigned NUM_PINS   = 8;
    localparam logic        PIN_LOW    = 1'b0;
    localparam logic [7:0]  PORT_RESET = 8'h00;

    // CPU states as presented by the power mode controller
    typedef enum logic [2:0]
    {
        CPU_POWER_ON,
        CPU_RUN,
        CPU_SLEEP,
        CPU_STANDBY,
        CPU_DEEP_STANDBY,
        CPU_DEEP_RETURN
    } cpu_state_t;

    // Per-pin configuration from peripherals and port registers
    typedef struct packed
    {
        logic periph_sel;
        logic periph_out;
        logic periph_oe;
        logic port_out;
        logic port_oe;
        logic analog_sel;
    } pin_cfg_t;

    // Per-pin drive toward the pad
    typedef struct packed
    {
        logic out;
        logic oe;
        logic in_internal;
        logic analog_en;
    } pin_drive_t;

    typedef enum
    {
        MODE_CONFIG,
        MODE_RESET,
        MODE_HOLD,
        MODE_HIZ
    } pin_mode_t;

endpackage

// ---- hdl/pin_cell.sv ----
/*
  One general-purpose pin cell: applies the current pin mode to one pin.
  Assumes the mode is decided by the enclosing controller.
*/
`timescale 1ns/100ps
module pin_cell
    import pin_state_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [1:0] mode_sel,
    input  wire pin_cfg_t   cfg,
    input  wire logic       pad_in,
    output pin_drive_t      drive
);

    typedef struct packed
    {
        pin_drive_t drv;
        logic       held_periph;
        logic       held_port_out;
        logic       held_oe;
    } cell_state_t;

    cell_state_t state_reg;
    cell_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        case (mode_sel)
            2'h0:
            begin
                state_next.held_periph   = cfg.periph_sel;
                state_next.held_port_out = cfg.port_out;
                state_next.held_oe       = cfg.periph_sel ? cfg.periph_oe : cfg.port_oe;
                state_next.drv.out       = cfg.periph_sel ? cfg.periph_out : cfg.port_out;
                state_next.drv.oe        = (cfg.periph_sel ? cfg.periph_oe : cfg.port_oe)
                                           & ~cfg.analog_sel;
                state_next.drv.analog_en = cfg.analog_sel;
                state_next.drv.in_internal = cfg.analog_sel ? PIN_LOW : pad_in;
            end
            2'h2:
            begin
                // Hold the enable and port level captured before the mode change; peripheral pins follow live periph_out
                state_next.drv.oe  = state_reg.held_oe & ~cfg.analog_sel;
                state_next.drv.out = state_reg.held_periph ? cfg.periph_out
                                                           : state_reg.held_port_out;
                state_next.drv.analog_en   = cfg.analog_sel;
                state_next.drv.in_internal = cfg.analog_sel ? PIN_LOW : pad_in;
            end
            default:
            begin
                // Reset and standby high impedance: driver off, input low
                state_next.drv.out         = PIN_LOW;
                state_next.drv.oe          = PIN_LOW;
                state_next.drv.in_internal = PIN_LOW;
                state_next.drv.analog_en   = cfg.analog_sel;
                if (mode_sel == 2'h1)
                begin
                    state_next.held_periph   = PIN_LOW;
                    state_next.held_port_out = PIN_LOW;
                    state_next.held_oe       = PIN_LOW;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign drive = state_reg.drv;

endmodule

// ---- hdl/pin_state_power_mode_control.sv ----
/*
  Pin state control across CPU states: per-pin cells for the general-purpose
  pins plus the main oscillator input pin.
  Assumes the power mode controller supplies the CPU state and the standby
  pin level setting, and that all inputs are synchronous to clk.
*/
`timescale 1ns/100ps
module pin_state_power_mode_control
    import pin_state_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       external_reset_n,
    input  wire cpu_state_t cpu_state,
    input  wire logic       standby_pin_level,
    input  wire pin_cfg_t   pin_cfg [NUM_PINS],
    input  wire logic [7:0] pad_in,
    input  wire logic       osc_pad_in,
    output logic      [7:0] pad_out,
    output logic      [7:0] pad_oe,
    output logic      [7:0] internal_in,
    output logic      [7:0] analog_en,
    output logic            osc_internal_in,
    output logic            deep_port_sel
);

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    typedef struct packed
    {
        logic       osc_in;
        logic       deep_port;
        logic [1:0] mode;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;
    pin_mode_t  pin_mode;
    logic [1:0] mode_code;
    logic       reset_active;
    logic       deep_entry;
    logic       deep_exit;
    pin_drive_t drive [NUM_PINS];
    pin_cfg_t   cell_cfg [NUM_PINS];

    //--------------------------------------------------------------
    // Reset and deep standby qualifiers
    //--------------------------------------------------------------
    always_comb
    begin
        reset_active = !external_reset_n || (cpu_state == CPU_POWER_ON);
        deep_entry   = external_reset_n && (cpu_state == CPU_DEEP_STANDBY);
        deep_exit    = reset_active || (cpu_state == CPU_RUN);
    end

    //--------------------------------------------------------------
    // Pin mode decision
    //--------------------------------------------------------------
    always_comb
    begin
        if (reset_active)
        begin
            pin_mode = MODE_RESET;
        end
        else
        begin
            case (cpu_state)
                CPU_RUN, CPU_SLEEP:
                    pin_mode = MODE_CONFIG;
                CPU_STANDBY, CPU_DEEP_STANDBY:
                begin
                    if (standby_pin_level)
                        pin_mode = MODE_HIZ;
                    else
                        pin_mode = MODE_HOLD;
                end
                CPU_DEEP_RETURN:
                    pin_mode = MODE_HOLD;
                default:
                    pin_mode = MODE_RESET;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Mode code toward the pin cells
    //--------------------------------------------------------------
    always_comb
    begin
        case (pin_mode)
            MODE_CONFIG:
                mode_code = 2'h0;
            MODE_RESET:
                mode_code = 2'h1;
            MODE_HOLD:
                mode_code = 2'h2;
            MODE_HIZ:
                mode_code = 2'h3;
            default:
                mode_code = 2'h1;
        endcase
    end

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb
    begin
        state_next        = state_reg;
        state_next.osc_in = osc_pad_in;
        state_next.mode   = mode_code;
        if (deep_exit)
            state_next.deep_port = PIN_LOW;
        else if (deep_entry)
            state_next.deep_port = 1'b1;
    end

    //--------------------------------------------------------------
    // Pin cells
    //--------------------------------------------------------------
    for (genvar i = 0; i < NUM_PINS; i++)
    begin : g_pin
        always_comb
        begin
            cell_cfg[i] = pin_cfg[i];
            if (state_reg.deep_port)
                cell_cfg[i].periph_sel = PIN_LOW;
        end

        pin_cell u_cell
        (
            .clk      (clk),
            .resetn   (resetn),
            .mode_sel (state_reg.mode),
            .cfg      (cell_cfg[i]),
            .pad_in   (pad_in[i]),
            .drive    (drive[i])
        );

        assign pad_out[i]     = drive[i].out;
        assign pad_oe[i]      = drive[i].oe;
        assign internal_in[i] = drive[i].in_internal;
        assign analog_en[i]   = drive[i].analog_en;
    end

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= '{osc_in: PIN_LOW, deep_port: PIN_LOW, mode: 2'h1};
        else
            state_reg <= state_next;
    end

    assign osc_internal_in = state_reg.osc_in;
    assign deep_port_sel   = state_reg.deep_port;

endmodule

// ---- bench/pin_state_properties.sv ----
/*
  Checker for the pin state block: timing relations at the top ports.
  Assumes a bind to the top module and one clock domain.
*/
`timescale 1ns/100ps
module pin_state_checker
    import pin_state_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       external_reset_n,
    input wire cpu_state_t cpu_state,
    input wire logic       standby_pin_level,
    input wire pin_cfg_t   pin_cfg [NUM_PINS],
    input wire logic [7:0] pad_in,
    input wire logic       osc_pad_in,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] internal_in,
    input wire logic [7:0] analog_en,
    input wire logic       osc_internal_in,
    input wire logic       deep_port_sel
);
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic run_q;
    assign run_q = cpu_state == CPU_RUN && external_reset_n;
    ext_reset_a: assert property (!external_reset_n [*3] |-> pad_oe == 8'h00 && internal_in == 8'h00)
        else $error("pins active in external reset");
    standby_hiz_a: assert property ((cpu_state == CPU_STANDBY && standby_pin_level && external_reset_n) [*3] |-> pad_oe == 8'h00 && internal_in == 8'h00)
        else $error("standby pins not hi-z");
    standby_hold_a: assert property ((cpu_state == CPU_STANDBY && !standby_pin_level && external_reset_n) [*4] |-> $stable(pad_oe))
        else $error("held enables changed");
    osc_pass_a: assert property ($past(resetn) |-> osc_internal_in == $past(osc_pad_in))
        else $error("oscillator input not passed");
    analog_path_a: assert property ((run_q && pin_cfg[7].analog_sel) [*3] |-> analog_en[7] && !pad_oe[7] && !internal_in[7])
        else $error("analog pin wrong");
    input_pass_a: assert property ((run_q && !pin_cfg[6].analog_sel && !pin_cfg[6].port_oe) [*3] |-> internal_in[6] == $past(pad_in[6]))
        else $error("pad level not passed");
    port_drive_a: assert property ((run_q && !pin_cfg[0].periph_sel && !pin_cfg[0].analog_sel) [*3] |-> pad_out[0] == $past(pin_cfg[0].port_out) && pad_oe[0] == $past(pin_cfg[0].port_oe))
        else $error("port output wrong");
    deep_port_a: assert property (cpu_state == CPU_DEEP_STANDBY && external_reset_n |-> ##[1:2] deep_port_sel)
        else $error("deep standby port select missing");
    cover property (pad_oe == 8'h00 && standby_pin_level);
    cover property ($rose(deep_port_sel));
    cover property (cpu_state == CPU_STANDBY && pad_oe != 8'h00);
endmodule

bind pin_state_power_mode_control pin_state_checker chk_i
(
    .clk(clk), .resetn(resetn), .external_reset_n(external_reset_n), .cpu_state(cpu_state),
    .standby_pin_level(standby_pin_level), .pin_cfg(pin_cfg), .pad_in(pad_in),
    .osc_pad_in(osc_pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .internal_in(internal_in),
    .analog_en(analog_en), .osc_internal_in(osc_internal_in), .deep_port_sel(deep_port_sel)
);

// ---- bench/tb_pin_state_power_mode_control.sv ----
/*
  Self-checking bench for the pin state block.
  Assumes the package and the design files are compiled first.
*/
`timescale 1ns/100ps
module tb_pin_state_power_mode_control
    import pin_state_pkg::*;
;
    logic       clk, resetn, external_reset_n, standby_pin_level, osc_pad_in;
    cpu_state_t cpu_state;
    pin_cfg_t   pin_cfg [NUM_PINS];
    logic [7:0] pad_in, pad_out, pad_oe, internal_in, analog_en;
    logic       osc_internal_in, deep_port_sel;
    int         fails, samples_checked;
    pin_state_power_mode_control dut
    (
        .clk(clk), .resetn(resetn), .external_reset_n(external_reset_n), .cpu_state(cpu_state),
        .standby_pin_level(standby_pin_level), .pin_cfg(pin_cfg), .pad_in(pad_in),
        .osc_pad_in(osc_pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .internal_in(internal_in),
        .analog_en(analog_en), .osc_internal_in(osc_internal_in), .deep_port_sel(deep_port_sel)
    );
    // ----
    // Scenarios
    // ----
    task finish_test;
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Pins 0-3 port out, 4-5 peripheral, 6 input, 7 analog
    task setcfg(input logic [7:0] po, input logic pf);
        for (int i = 0; i < NUM_PINS; i++)
            pin_cfg[i] = {i inside {[4:5]}, pf, i inside {[4:5]}, po[i], i < 4, i == 7};
    endtask
    task ext_reset_test;
        setcfg(8'h0f, 1'b1);
        pad_in = 8'hff;
        cyc(3);
        chk("por_oe", 8'h00, pad_oe);
        chk("por_in", 8'h00, internal_in);
        cpu_state = CPU_RUN;
        external_reset_n = 1'b0;
        cyc(3);
        chk("oe", 8'h00, pad_oe);
        chk("in", 8'h00, internal_in);
        external_reset_n = 1'b1;
        cyc(3);
        chk("oe", 8'h3f, pad_oe);
    endtask
    task run_test;
        setcfg(8'h05, 1'b1);
        pad_in = 8'h40;
        cyc(3);
        chk("out", 8'h35, pad_out & 8'h3f);
        chk("in", 8'h40, internal_in & 8'h40);
        chk("analog", 8'h80, analog_en);
    endtask
    task hold_test;
        standby_pin_level = 1'b0;
        cpu_state = CPU_STANDBY;
        cyc(3);
        setcfg(8'h0a, 1'b0);
        cyc(2);
        chk("held", 8'h05, pad_out & 8'h0f);
        chk("periph", 8'h00, pad_out & 8'h30);
        chk("oe", 8'h3f, pad_oe);
    endtask
    task hiz_test;
        standby_pin_level = 1'b1;
        pad_in = 8'hff;
        cyc(3);
        chk("oe", 8'h00, pad_oe);
        chk("in", 8'h00, internal_in);
    endtask
    task deep_test;
        cpu_state = CPU_DEEP_STANDBY;
        osc_pad_in = 1'b1;
        cyc(3);
        chk("deep", 8'h01, {7'h00, deep_port_sel});
        chk("osc", 8'h01, {7'h00, osc_internal_in});
        cpu_state = CPU_RUN;
        cyc(3);
        chk("deep", 8'h00, {7'h00, deep_port_sel});
    endtask
    task return_test;
        setcfg(8'h03, 1'b1);
        cpu_state = CPU_SLEEP;
        standby_pin_level = 1'b0;
        cyc(3);
        chk("sleep", 8'h33, pad_out & 8'h3f);
        cpu_state = CPU_DEEP_STANDBY;
        cyc(3);
        chk("deep", 8'h01, {7'h00, deep_port_sel});
        setcfg(8'h0c, 1'b1);
        cpu_state = CPU_DEEP_RETURN;
        cyc(3);
        chk("return", 8'h33, pad_out & 8'h3f);
        chk("oe", 8'h3f, pad_oe);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        #20000;
        fails++;
        finish_test();
    end
    initial
    begin
        resetn = 1'b0;
        external_reset_n = 1'b1;
        cpu_state = CPU_POWER_ON;
        standby_pin_level = 1'b0;
        osc_pad_in = 1'b0;
        pad_in = 8'h00;
        fails = 0;
        samples_checked = 0;
        setcfg(8'h00, 1'b0);
        cyc(12);
        resetn = 1'b1;
        ext_reset_test();
        run_test();
        hold_test();
        hiz_test();
        deep_test();
        return_test();
        finish_test();
    end
endmodule
